// ==== slrx_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SLRX_REGS_SVH
`define SLRX_REGS_SVH
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------

//------------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------------
`define SLRX_OFS_RSR 12'h000
`define SLRX_OFS_TSR 12'h004
`define SLRX_OFS_RBUF 12'h008

//------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------
`define SLRX_RSR_MCTL 3:1
`define SLRX_RSR_SRCH 4
`define SLRX_RSR_ACT 5
`define SLRX_RSR_DONE 7
`define SLRX_RSR_LEN 9:8
`define SLRX_RSR_DSC 15
`define SLRX_TSR_BRK 0
`define SLRX_TSR_MS 2:1
`define SLRX_TSR_BITA 3
`define SLRX_TSR_SS 4
`define SLRX_TSR_RXIN 5
`define SLRX_RBUF_DATA 7:0
`define SLRX_RBUF_FRM 12
`define SLRX_RBUF_OVR 14

//------------------------------------------------------------------
// Reset values and timing
//------------------------------------------------------------------
`define SLRX_CTL_RST 8'h00
`define SLRX_RBUF_RST 8'h00
`define SLRX_TCLK_HALF 8'h08
`endif

// ==== slrx_pkg.sv ====
// Types shared by the loopback receiver
package slrx_pkg;
  // Maintenance mode, in the order of {select_high, select_low}
  typedef enum logic [1:0] {SLRX_NORMAL, SLRX_EXT_LOOP, SLRX_INT_LOOP,
                            SLRX_SYS_TEST} slrx_mode_t;
  // Receiver framing states
  typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_DATA, RX_STOP} slrx_state_t;
  // Control bits carried to the link domain
  typedef struct packed {
    logic [1:0] ms;
    logic bit_a;
    logic ss;
    logic brk;
    logic srch;
    logic [1:0] len;
  } slrx_ctl_t;
  // One framed character
  typedef struct packed {
    logic [7:0] data;
    logic frm;
  } slrx_char_t;
endpackage

// ==== slrx_top.sv ====
// Start/stop receiver with maintenance loopback and clock selection
`timescale 1ns/1ns
`include "slrx_regs.svh"
module slrx_top
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link clock and modem pins
  input wire logic link_clk_i,
  input wire logic modem_rx_clock_i,
  input wire logic modem_tx_clock_i,
  input wire logic modem_data_i,
  input wire logic [2:0] modem_status_i,
  output logic serial_out_o,
  output logic external_clock_out_o,
  output logic [2:0] modem_ctl_o,
  // Transmitter side
  input wire logic tx_serial_i,
  output logic tx_bit_clk_o
);
  import slrx_pkg::*;

  //----------------------------------------------------------------
  // APB decode
  //----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  slrx_ctl_t ctl_q;
  logic [2:0] mctl_q;
  logic act_q, done_q, dsc_q, frm_q, ovr_q;
  logic [7:0] rbuf_q;
  logic [2:0] tgl_s;
  logic [1:0] rxin_s;
  logic [2:0] st_s1, st_s2, st_s3;
  slrx_char_t lchr_q;
  logic tclk_q, rclk_prev_q, rx_in_q, chr_tgl_q;
  logic [31:0] rd_word;

  // Request decode; pready registered from the setup phase gives no wait states, keeping the slave simple
  wire setup = psel_i & ~penable_i;
  wire acc = psel_i & penable_i & pready_q;
  wire hit_rsr = hit(paddr_i, `SLRX_OFS_RSR);
  wire hit_tsr = hit(paddr_i, `SLRX_OFS_TSR);
  wire hit_rbuf = hit(paddr_i, `SLRX_OFS_RBUF);
  wire mapped = hit_rsr | hit_tsr | hit_rbuf;
  wire wr_rsr = acc & pwrite_i & hit_rsr;
  wire wr_tsr = acc & pwrite_i & hit_tsr;
  // Reads clear done, overrun and dsc at setup, with the word the read returns, so a
  // character or line change landing at that edge is never lost
  wire rd_rsr = setup & ~pwrite_i & hit_rsr;
  wire rd_rbuf = setup & ~pwrite_i & hit_rbuf;
  wire char_evt = tgl_s[1] ^ tgl_s[2];
  wire chg_evt = |(st_s2 ^ st_s3);

  // Read data assembly, unused bits read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_rsr)
    begin
      rd_word[`SLRX_RSR_MCTL] = mctl_q;
      rd_word[`SLRX_RSR_SRCH] = ctl_q.srch;
      rd_word[`SLRX_RSR_ACT] = act_q;
      rd_word[`SLRX_RSR_DONE] = done_q;
      rd_word[`SLRX_RSR_LEN] = ctl_q.len;
      rd_word[`SLRX_RSR_DSC] = dsc_q;
    end
    if (hit_tsr)
    begin
      rd_word[`SLRX_TSR_BRK] = ctl_q.brk;
      rd_word[`SLRX_TSR_MS] = ctl_q.ms;
      rd_word[`SLRX_TSR_BITA] = ctl_q.bit_a;
      rd_word[`SLRX_TSR_SS] = ctl_q.ss;
      rd_word[`SLRX_TSR_RXIN] = rxin_s[1];
    end
    if (hit_rbuf)
    begin
      rd_word[`SLRX_RBUF_DATA] = rbuf_q;
      rd_word[`SLRX_RBUF_FRM] = frm_q;
      rd_word[`SLRX_RBUF_OVR] = ovr_q;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= setup ? rd_word : 32'h0000_0000;
    end
  end

  // Bus answer straight from its registers
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  //----------------------------------------------------------------
  // Control registers
  //----------------------------------------------------------------
  // Software control; modem lines stay live in every mode
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_q <= `SLRX_CTL_RST;
      mctl_q <= 3'h0;
      act_q <= 1'b0;
    end
    else
    begin
      if (wr_rsr)
      begin
        mctl_q <= pwdata_i[`SLRX_RSR_MCTL];
        ctl_q.srch <= pwdata_i[`SLRX_RSR_SRCH];
        act_q <= pwdata_i[`SLRX_RSR_SRCH];
        ctl_q.len <= pwdata_i[`SLRX_RSR_LEN];
      end
      if (wr_tsr)
      begin
        ctl_q.brk <= pwdata_i[`SLRX_TSR_BRK];
        ctl_q.ms <= pwdata_i[`SLRX_TSR_MS];
        ctl_q.bit_a <= pwdata_i[`SLRX_TSR_BITA];
        ctl_q.ss <= pwdata_i[`SLRX_TSR_SS];
      end
    end
  end

  //----------------------------------------------------------------
  // Receive buffer and status flags
  //----------------------------------------------------------------
  // Toggle and level synchronisers from the link domain, and a change detector on the modem status pins
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tgl_s <= 3'h0;
      rxin_s <= 2'h3;
      st_s1 <= 3'h0;
      st_s2 <= 3'h0;
      st_s3 <= 3'h0;
    end
    else
    begin
      tgl_s <= {tgl_s[1:0], chr_tgl_q};
      rxin_s <= {rxin_s[0], rx_in_q};
      st_s1 <= modem_status_i;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
    end
  end

  // New characters win over a same-cycle buffer read
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rbuf_q <= `SLRX_RBUF_RST;
      done_q <= 1'b0;
      frm_q <= 1'b0;
      ovr_q <= 1'b0;
      dsc_q <= 1'b0;
    end
    else
    begin
      if (char_evt)
      begin
        rbuf_q <= lchr_q.data;
        done_q <= 1'b1;
        frm_q <= lchr_q.frm;
        ovr_q <= done_q & ~rd_rbuf;
      end
      else if (rd_rbuf)
      begin
        done_q <= 1'b0;
        ovr_q <= 1'b0;
      end
      if (chg_evt)
        dsc_q <= 1'b1;
      else if (rd_rsr)
        dsc_q <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // Link domain: reset, synchronisers, clock and data selection
  //----------------------------------------------------------------
  logic [1:0] lrst_q;
  slrx_ctl_t cs1_q, cs2_q;
  logic [1:0] rxc_s, txc_s, dat_s, txd_s;
  logic [7:0] tdiv_q;
  slrx_state_t st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  wire lrst_n = lrst_q[1];

  // Reset released in step with the link clock
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end

  // Quasi-static control; software changes it between characters
  always_ff @(posedge link_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      cs1_q <= `SLRX_CTL_RST;
      cs2_q <= `SLRX_CTL_RST;
      rxc_s <= 2'h0;
      txc_s <= 2'h0;
      dat_s <= 2'h3;
      txd_s <= 2'h3;
    end
    else
    begin
      cs1_q <= ctl_q;
      cs2_q <= cs1_q;
      rxc_s <= {rxc_s[0], modem_rx_clock_i};
      txc_s <= {txc_s[0], modem_tx_clock_i};
      dat_s <= {dat_s[0], modem_data_i};
      txd_s <= {txd_s[0], tx_serial_i};
    end
  end

  wire slrx_mode_t mode = slrx_mode_t'(cs2_q.ms);
  wire modem_on = (mode == SLRX_NORMAL) | (mode == SLRX_EXT_LOOP);
  wire loop_on = (mode == SLRX_INT_LOOP) | (mode == SLRX_EXT_LOOP);
  wire loop_back = (mode == SLRX_INT_LOOP) | (mode == SLRX_SYS_TEST);
  // Bit clock selection: modem clocks blocked unless enabled
  wire rclk_sel = (mode == SLRX_SYS_TEST) ? tclk_q :
                  (mode == SLRX_INT_LOOP) ? cs2_q.ss :
                  rxc_s[1];
  wire tclk_sel = (mode == SLRX_SYS_TEST) ? tclk_q :
                  (mode == SLRX_INT_LOOP) ? cs2_q.ss :
                  txc_s[1];
  // Input selector; software data only while break holds the output idle
  wire din_sel = (loop_on & cs2_q.brk) ? cs2_q.bit_a :
                 loop_back ? txd_s[1] :
                 dat_s[1];
  wire bit_edge = rclk_sel & ~rclk_prev_q;
  wire [2:0] last_bit = 3'(3'd4 + {1'b0, cs2_q.len});

  // On-board test clock divider, free running
  always_ff @(posedge link_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      tdiv_q <= 8'h00;
      tclk_q <= 1'b0;
    end
    else if (tdiv_q == 8'(`SLRX_TCLK_HALF - 8'h01))
    begin
      tdiv_q <= 8'h00;
      tclk_q <= ~tclk_q;
    end
    else
      tdiv_q <= 8'(tdiv_q + 8'h01);
  end

  // Link outputs; break, internal loop or system test holds the line at mark
  always_ff @(posedge link_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      serial_out_o <= 1'b1;
      external_clock_out_o <= 1'b0;
      tx_bit_clk_o <= 1'b0;
      rclk_prev_q <= 1'b0;
      rx_in_q <= 1'b1;
    end
    else
    begin
      serial_out_o <= (modem_on & ~cs2_q.brk) ? txd_s[1] : 1'b1;
      external_clock_out_o <= (mode == SLRX_EXT_LOOP) & cs2_q.ss;
      tx_bit_clk_o <= tclk_sel;
      rclk_prev_q <= rclk_sel;
      rx_in_q <= din_sel;
    end
  end

  // Modem control lines follow software directly
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      modem_ctl_o <= 3'h0;
    else
      modem_ctl_o <= mctl_q;
  end

  //----------------------------------------------------------------
  // Link domain: character framing
  //----------------------------------------------------------------
  // One sample per rising bit clock; held result stays put for the
  // whole next character, long enough for the toggle to cross
  always_ff @(posedge link_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st_q <= RX_OFF;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      lchr_q <= 9'h000;
      chr_tgl_q <= 1'b0;
    end
    else if (!cs2_q.srch)
      st_q <= RX_OFF;
    else if (bit_edge)
    begin
      case (st_q)
        RX_OFF:
          st_q <= RX_HUNT;
        RX_HUNT:
        begin
          cnt_q <= 3'h0;
          if (!din_sel)
            st_q <= RX_DATA;
        end
        RX_DATA:
        begin
          sh_q <= {din_sel, sh_q[7:1]};
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q == last_bit)
            st_q <= RX_STOP;
        end
        RX_STOP:
        begin
          lchr_q.data <= sh_q >> (2'd3 - cs2_q.len);
          lchr_q.frm <= ~din_sel;
          chr_tgl_q <= ~chr_tgl_q;
          st_q <= RX_HUNT;
        end
        default:
          st_q <= RX_OFF;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  property p_active;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_rsr |=> (act_q == $past(pwdata_i[`SLRX_RSR_SRCH]));
  endproperty
  a_active: assert property (p_active)
    else $error("receiver active not following search enable");

  property p_hunt;
    @(posedge link_clk_i) disable iff (!lrst_n)
    (st_q == RX_HUNT && bit_edge && din_sel && cs2_q.srch) |=>
      (st_q == RX_HUNT);
  endproperty
  a_hunt: assert property (p_hunt)
    else $error("framing began without a start bit");

  property p_done;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(done_q) |-> $past(char_evt) && (rbuf_q == $past(lchr_q.data));
  endproperty
  a_done: assert property (p_done)
    else $error("receive done without a loaded character");

  property p_frame;
    @(posedge link_clk_i) disable iff (!lrst_n)
    (st_q == RX_STOP && bit_edge && cs2_q.srch) |=>
      (lchr_q.frm == !$past(din_sel)) && (st_q == RX_HUNT);
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing error not tied to stop bit");

  property p_overrun;
    @(posedge clk_i) disable iff (!reset_n_i)
    (char_evt && done_q && !rd_rbuf) |=> ovr_q && done_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_block;
    @(posedge link_clk_i) disable iff (!lrst_n)
    (mode == SLRX_INT_LOOP) |=> serial_out_o;
  endproperty
  a_block: assert property (p_block)
    else $error("serial output reached the modem in internal loop");

  property p_extclk;
    @(posedge link_clk_i) disable iff (!lrst_n)
    ##1 (external_clock_out_o ==
         ($past(mode == SLRX_EXT_LOOP) && $past(cs2_q.ss)));
  endproperty
  a_extclk: assert property (p_extclk)
    else $error("clock output not driven by single step bit");

  property p_dsc;
    @(posedge clk_i) disable iff (!reset_n_i)
    chg_evt |=> dsc_q;
  endproperty
  a_dsc: assert property (p_dsc)
    else $error("modem line change not flagged");

  property p_normal;
    @(posedge link_clk_i) disable iff (!lrst_n)
    (mode == SLRX_NORMAL) |-> (rclk_sel == rxc_s[1]) &&
      (din_sel == dat_s[1]);
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal mode not using modem clock and data");
endmodule

// ==== slrx_modem_model.sv ====
// Modem and looped-back test connector at the line side of the receiver
`timescale 1ns/1ns
module slrx_modem_model
(
  // Bench controls: connector fitted, pins jammed
  input wire logic loop_i,
  input wire logic jam_i,
  // Device side of the cable
  input wire logic serial_out_i,
  input wire logic external_clock_out_i,
  input wire logic [2:0] modem_ctl_i,
  output logic modem_rx_clock_o,
  output logic modem_tx_clock_o,
  output logic modem_data_o,
  output logic [2:0] modem_status_o
);
  logic mclk = 1'b0;
  logic mdat = 1'b1;

  //----------------------------------------------------------------
  // Cable routing
  //----------------------------------------------------------------
  // Connector returns clock out, data out and controls to the inputs
  assign modem_rx_clock_o = loop_i ? external_clock_out_i : mclk;
  assign modem_tx_clock_o = loop_i ? external_clock_out_i : mclk;
  assign modem_data_o = loop_i ? serial_out_i : mdat;
  assign modem_status_o = loop_i ? modem_ctl_i : 3'h0;

  // Noise on clock and data, so a path that should be blocked shows
  always #300
    if (jam_i)
    begin
      mclk = ~mclk;
      mdat = ~mdat;
    end

  // One bit cell; the clock stands still low between cells
  task automatic send_bit(input logic b);
    mdat = b;
    #400;
    mclk = 1'b1;
    #400;
    mclk = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the loopback receiver
`timescale 1ns/1ns
`include "slrx_regs.svh"
module testbench;
  import slrx_pkg::*;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_q;
  logic loop_q = 1'b0, jam_q = 1'b0, tx_serial_q = 1'b1;
  wire logic rx_clk, tx_clk, m_data, ser_out, ext_clk, tx_bit_clk;
  wire logic [2:0] m_status, m_ctl;
  logic [31:0] tsr_q = 32'h0;
  int how_q = 0;
  int err_count = 0;
  int checks_done = 0;

  // Clocks: link clock offset so the two never line up
  always #50 clk_i = ~clk_i;
  initial
  begin
    #7;
    forever #24 link_clk_i = ~link_clk_i;
  end

  slrx_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link_clk_i(link_clk_i),
    .modem_rx_clock_i(rx_clk), .modem_tx_clock_i(tx_clk),
    .modem_data_i(m_data), .modem_status_i(m_status),
    .serial_out_o(ser_out), .external_clock_out_o(ext_clk),
    .modem_ctl_o(m_ctl), .tx_serial_i(tx_serial_q),
    .tx_bit_clk_o(tx_bit_clk));

  slrx_modem_model u_modem (.loop_i(loop_q), .jam_i(jam_q),
    .serial_out_i(ser_out), .external_clock_out_i(ext_clk),
    .modem_ctl_i(m_ctl), .modem_rx_clock_o(rx_clk),
    .modem_tx_clock_o(tx_clk), .modem_data_o(m_data),
    .modem_status_o(m_status));

  //----------------------------------------------------------------
  // Reporting
  //----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  //----------------------------------------------------------------
  // Bus cycles
  //----------------------------------------------------------------
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Bounded poll of a field; a timeout ends the run
  task automatic poll(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while ((rd & m) !== v && n < 100);
    chk(rd & m, v);
    if (n >= 100)
      finish_test();
  endtask

  //----------------------------------------------------------------
  // Line stimulus
  //----------------------------------------------------------------
  task automatic wait_tx(input logic lvl);
    int n;
    n = 0;
    while (tx_bit_clk !== lvl && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      finish_test();
    end
  endtask

  // 0 modem, 1 single step on transmitter, 2 single step on bit_a,
  // 3 on-board test clock
  task automatic put_bit(input logic b);
    logic [31:0] a;
    a = (how_q == 2) ? {28'h0, b, 3'h0} : 32'h0;
    if (how_q == 0)
      u_modem.send_bit(b);
    else if (how_q == 3)
    begin
      wait_tx(1'b1);
      wait_tx(1'b0);
      tx_serial_q <= b;
    end
    else
    begin
      // Data moves only while the step clock is low; data and clock
      // paths are equally deep, so moving it at the rise would race
      wr(`SLRX_OFS_TSR, tsr_q | a);
      if (how_q == 1)
        tx_serial_q <= b;
      wr(`SLRX_OFS_TSR, tsr_q | a | 32'h10);
    end
  endtask

  // Two idle cells, start, data LSB first, stop, one idle cell
  task automatic frame(input logic [7:0] d, input int nb, input logic stp);
    for (int i = 0; i < nb + 5; i++)
      put_bit(i == 2 ? 1'b0 : (i > 2 && i < nb + 3) ? d[i - 3] :
              (i == nb + 3) ? stp : 1'b1);
  endtask

  task automatic rx(input logic [7:0] d, input int nb, input logic stp,
                    input logic [31:0] exp);
    frame(d, nb, stp);
    poll(`SLRX_OFS_RSR, 32'h80, 32'h80);
    rdc(`SLRX_OFS_RBUF, exp);
  endtask

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Reset state and an unmapped word
    rdc(`SLRX_OFS_RSR, 32'h0);
    rdc(`SLRX_OFS_RBUF, 32'h0);
    chk({ser_out, ext_clk, m_ctl}, 32'h10);
    rdc(12'h00C, 32'h0);
    chk(err_q, 32'h1);
    // Normal mode, 8 and 5 bit characters, overrun
    wr(`SLRX_OFS_RSR, 32'h310);
    rdc(`SLRX_OFS_RSR, 32'h330);
    rx(8'hA5, 8, 1'b1, 32'h00A5);
    wr(`SLRX_OFS_RSR, 32'h010);
    rx(8'h3B, 5, 1'b0, 32'h101B);
    wr(`SLRX_OFS_RSR, 32'h310);
    frame(8'h11, 8, 1'b1);
    rx(8'hC4, 8, 1'b1, 32'h40C4);
    rdc(`SLRX_OFS_RBUF, 32'h00C4);
    // External loop through the connector, clocked by single step
    loop_q <= 1'b1;
    how_q = 1;
    tsr_q = {29'h0, SLRX_EXT_LOOP, 1'b0};
    wr(`SLRX_OFS_TSR, tsr_q);
    rx(8'h6E, 8, 1'b1, 32'h006E);
    chk({ext_clk, tx_bit_clk}, 32'h3);
    // Break set while bit_a feeds the receiver
    tsr_q = tsr_q | 32'h1;
    how_q = 2;
    tx_serial_q <= 1'b0;
    rx(8'h93, 8, 1'b1, 32'h0093);
    chk(ser_out, 32'h1);
    wr(`SLRX_OFS_TSR, tsr_q | 32'h10);
    poll(`SLRX_OFS_TSR, 32'h20, 32'h0);
    wr(`SLRX_OFS_TSR, tsr_q | 32'h18);
    poll(`SLRX_OFS_TSR, 32'h20, 32'h20);
    // Each modem control line set alone and seen back as a change
    for (int i = 0; i < 3; i++)
    begin
      wr(`SLRX_OFS_RSR, 32'h310 | (32'h2 << i));
      poll(`SLRX_OFS_RSR, 32'h8000, 32'h8000);
      chk(m_ctl, 32'h1 << i);
      rdc(`SLRX_OFS_RSR, 32'h330 | (32'h2 << i));
    end
    // Internal loop with the modem pins jammed
    loop_q <= 1'b0;
    jam_q <= 1'b1;
    how_q = 1;
    tsr_q = {29'h0, SLRX_INT_LOOP, 1'b0};
    wr(`SLRX_OFS_TSR, tsr_q);
    tx_serial_q <= 1'b0;
    wr(`SLRX_OFS_RSR, 32'h31E);
    poll(`SLRX_OFS_TSR, 32'h20, 32'h0);
    chk(ser_out, 32'h1);
    rx(8'h5C, 8, 1'b1, 32'h005C);
    chk({ext_clk, tx_bit_clk}, 32'h1);
    chk(m_ctl, 32'h7);
    // System test on the on-board clock, modem still jammed
    how_q = 3;
    tx_serial_q <= 1'b1;
    tsr_q = {29'h0, SLRX_SYS_TEST, 1'b0};
    wr(`SLRX_OFS_TSR, tsr_q);
    wr(`SLRX_OFS_RSR, 32'h310);
    rx(8'hE7, 8, 1'b1, 32'h00E7);
    chk(ser_out, 32'h1);
    finish_test();
  end
endmodule
